/* File: inc/cri_pkg.sv */
package cri_pkg;
    localparam logic [15:0] CRI_FLAGS_RST = 16'h0002;
    localparam logic [15:0] CRI_IP_RST = 16'hfff0;
    localparam logic [15:0] CRI_CS_RST = 16'hf000;
    localparam logic [15:0] CRI_SEG_RST = 16'h0000;
    localparam logic [15:0] CRI_MSW_RST = 16'hfff0;
    localparam logic [15:0] CRI_OFF_LAST = 16'hffff;
    localparam logic [23:0] CRI_BOOT_ADDR = 24'h0ffff0;
    localparam int CRI_MSW_PE = 0;
    localparam int CRI_MSW_MP = 1;
    localparam int CRI_MSW_EM = 2;
    localparam int CRI_MSW_TS = 3;
    localparam int CRI_FLAG_RSV = 1;
    localparam int CRI_FLAG_TF = 8;
    localparam int CRI_FLAG_IF = 9;
    localparam logic [7:0] CRI_VEC_STEP = 8'h01;
    localparam logic [7:0] CRI_VEC_NMI = 8'h02;
    localparam logic [7:0] CRI_VEC_NOCOP = 8'h07;
    localparam logic [7:0] CRI_VEC_OVRUN = 8'h09;
    localparam logic [7:0] CRI_VEC_WRAP = 8'h0d;
    localparam logic [1:0] CRI_SEG_DS = 2'h1;
    localparam logic [1:0] CRI_SEG_ES = 2'h2;
    localparam logic [1:0] CRI_SEG_SS = 2'h3;
    localparam int CRI_RESET_GAP = 8;

    typedef enum logic [2:0] {CRI_RESET, CRI_RUN, CRI_SVC, CRI_WAIT, CRI_HALT} cri_state_e;

    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] cs;
        logic [15:0] ip;
        logic [7:0] vector;
    } cri_frame_s;

    typedef struct packed {
        logic [15:0] sel;
        logic [15:0] off;
        logic word;
    } cri_mem_s;
endpackage

/* File: hw/cri_ctrl.sv */
`timescale 1ns/100ps
module cri_ctrl #(
    parameter int RESET_GAP = cri_pkg::CRI_RESET_GAP
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic nmi_pin,
    input wire logic maskable_request,
    input wire logic [7:0] maskable_request_vector,
    input wire logic instr_done,
    input wire logic [15:0] next_cs,
    input wire logic [15:0] next_ip,
    input wire logic flags_wr,
    input wire logic [15:0] flags_wr_data,
    input wire logic [1:0] seg_wr_sel,
    input wire logic [15:0] seg_wr_data,
    input wire logic sw_int,
    input wire logic [7:0] sw_vector,
    input wire logic ovrun_req,
    input wire logic coproc_escape_instr,
    input wire logic coproc_wait_instr,
    input wire logic load_status_word_instr,
    input wire logic [15:0] load_status_word_instr_data,
    input wire logic store_status_word_instr,
    input wire logic halt_instr,
    input wire logic iret_done,
    input wire logic mem_req,
    input wire cri_pkg::cri_mem_s mem,
    input wire logic entry_valid,
    input wire logic [15:0] entry_cs,
    input wire logic [15:0] entry_ip,
    output logic exec_enable,
    output logic fetch_start,
    output logic mem_valid,
    output logic [23:0] phys_addr,
    output logic high_byte_enable,
    output logic frame_valid,
    output cri_pkg::cri_frame_s frame,
    output logic [15:0] code_segment,
    output logic [15:0] instruction_pointer,
    output logic [15:0] data_segment,
    output logic [15:0] extra_segment,
    output logic [15:0] stack_segment,
    output logic [15:0] flag_word,
    output logic [15:0] machine_status_word,
    output logic store_status_word_instr_valid,
    output logic protected_mode,
    output logic halted
);
    import cri_pkg::*;

    localparam int GW = $clog2(RESET_GAP + 1);

    // base is selector times 16, carry past bit 19 dropped
    function automatic logic [19:0] cri_phys(input logic [15:0] sel, input logic [15:0] off);
        cri_phys = {sel, 4'h0} + {4'h0, off};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    cri_state_e state_reg, state_next;
    logic [GW-1:0] gap_reg;
    logic [2:0] nmi_sync_reg, maskable_request_sync_reg;
    logic nmi_lvl_reg, maskable_request_lvl_reg;
    logic exc_pend_reg, step_pend_reg, nmi_pend_reg, ovr_pend_reg, nmi_block_reg;
    logic [7:0] exc_vec_reg;
    logic [15:0] cs_reg, ip_reg, ds_reg, es_reg, ss_reg, flags_reg, msw_reg;
    logic exec_reg, fetch_reg, mem_valid_reg, bhe_reg, frame_valid_reg, store_status_word_instr_reg, halted_reg;
    logic [23:0] phys_reg;
    cri_frame_s frame_reg;
    logic nmi_rise, running, maskable_request_ok, nmi_ok, ovr_ok, any_pend;
    logic take_exc, take_step, take_nmi, take_ovr, take_maskable_request;
    logic trap_nocop, trap_wrap, mem_go;
    logic [7:0] pick_vec;

    ////////////////////////////////////////////////////////////////////////////
    // pins cross in through three stages; level moves only when 2 and 3 agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            nmi_sync_reg <= 3'h0;
            maskable_request_sync_reg <= 3'h0;
            nmi_lvl_reg <= 1'b0;
            maskable_request_lvl_reg <= 1'b0;
        end else begin
            nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin};
            maskable_request_sync_reg <= {maskable_request_sync_reg[1:0], maskable_request};
            if (nmi_sync_reg[2] == nmi_sync_reg[1]) begin
                nmi_lvl_reg <= nmi_sync_reg[2];
            end
            if (maskable_request_sync_reg[2] == maskable_request_sync_reg[1]) begin
                maskable_request_lvl_reg <= maskable_request_sync_reg[2];
            end
        end
    end

    assign nmi_rise = (nmi_sync_reg[2] == nmi_sync_reg[1]) && nmi_sync_reg[2] && !nmi_lvl_reg;

    ////////////////////////////////////////////////////////////////////////////
    assign running = (state_reg == CRI_RUN);
    // escape traps on emulate or task switched; wait only with monitor too
    assign trap_nocop = running && ((coproc_escape_instr && (msw_reg[CRI_MSW_EM]
        || msw_reg[CRI_MSW_TS])) || (coproc_wait_instr && msw_reg[CRI_MSW_MP]
        && msw_reg[CRI_MSW_TS]));
    // a word at the last offset would wrap, so no bus cycle is run
    assign trap_wrap = running && mem_req && mem.word && (mem.off == CRI_OFF_LAST);
    assign mem_go = running && mem_req && !trap_wrap;

    // nmi handler shuts out further nmi, overrun and maskable until return
    assign maskable_request_ok = maskable_request_lvl_reg && flags_reg[CRI_FLAG_IF] && !nmi_block_reg;
    assign nmi_ok = nmi_pend_reg && !nmi_block_reg;
    assign ovr_ok = ovr_pend_reg && !nmi_block_reg;
    assign any_pend = exc_pend_reg || step_pend_reg || nmi_ok || ovr_ok || maskable_request_ok;

    always_comb begin
        take_exc = 1'b0;
        take_step = 1'b0;
        take_nmi = 1'b0;
        take_ovr = 1'b0;
        take_maskable_request = 1'b0;
        pick_vec = maskable_request_vector;
        if (state_reg == CRI_SVC) begin
            if (exc_pend_reg) begin
                take_exc = 1'b1;
                pick_vec = exc_vec_reg;
            end else if (step_pend_reg) begin
                take_step = 1'b1;
                pick_vec = CRI_VEC_STEP;
            end else if (nmi_ok) begin
                take_nmi = 1'b1;
                pick_vec = CRI_VEC_NMI;
            end else if (ovr_ok) begin
                take_ovr = 1'b1;
                pick_vec = CRI_VEC_OVRUN;
            end else begin
                take_maskable_request = maskable_request_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CRI_RESET: begin
                if (gap_reg == GW'(RESET_GAP)) begin
                    state_next = CRI_RUN;
                end
            end
            CRI_RUN: begin
                if (any_pend) begin
                    state_next = CRI_SVC;
                end else if (halt_instr) begin
                    state_next = CRI_HALT;
                end
            end
            CRI_SVC: begin
                state_next = any_pend ? CRI_WAIT : CRI_RUN;
            end
            CRI_WAIT: begin
                if (entry_valid) begin
                    // chain remaining requests before the handler's first fetch
                    state_next = any_pend ? CRI_SVC : CRI_RUN;
                end
            end
            CRI_HALT: begin
                if (nmi_ok || maskable_request_ok) begin
                    state_next = CRI_SVC;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= CRI_RESET;
            gap_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg == CRI_RESET) begin
                gap_reg <= gap_reg + GW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending flags: a new request in the same cycle as the take wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            exc_pend_reg <= 1'b0;
            exc_vec_reg <= 8'h00;
            step_pend_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
            ovr_pend_reg <= 1'b0;
            nmi_block_reg <= 1'b0;
        end else begin
            if (trap_nocop || trap_wrap || (running && sw_int)) begin
                exc_pend_reg <= 1'b1;
                exc_vec_reg <= trap_nocop ? CRI_VEC_NOCOP : (trap_wrap ? CRI_VEC_WRAP : sw_vector);
            end else if (take_exc) begin
                exc_pend_reg <= 1'b0;
            end
            step_pend_reg <= (running && instr_done && flags_reg[CRI_FLAG_TF])
                || (step_pend_reg && !take_step);
            nmi_pend_reg <= nmi_rise || (nmi_pend_reg && !take_nmi);
            ovr_pend_reg <= ovrun_req || (ovr_pend_reg && !take_ovr);
            if (take_nmi) begin
                nmi_block_reg <= 1'b1;
            end else if (iret_done) begin
                nmi_block_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cs_reg <= CRI_CS_RST;
            ip_reg <= CRI_IP_RST;
            flags_reg <= CRI_FLAGS_RST;
        end else if (state_reg == CRI_WAIT && entry_valid) begin
            cs_reg <= entry_cs;
            ip_reg <= entry_ip;
            flags_reg[CRI_FLAG_IF] <= 1'b0;
            flags_reg[CRI_FLAG_TF] <= 1'b0;
        end else begin
            // after halt the core has already stepped ip past it
            if (running && instr_done) begin
                cs_reg <= next_cs;
                ip_reg <= next_ip;
            end
            if (flags_wr) begin
                flags_reg <= flags_wr_data | (16'h0001 << CRI_FLAG_RSV);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ds_reg <= CRI_SEG_RST;
            es_reg <= CRI_SEG_RST;
            ss_reg <= CRI_SEG_RST;
        end else begin
            if (seg_wr_sel == CRI_SEG_DS) begin
                ds_reg <= seg_wr_data;
            end
            if (seg_wr_sel == CRI_SEG_ES) begin
                es_reg <= seg_wr_data;
            end
            if (seg_wr_sel == CRI_SEG_SS) begin
                ss_reg <= seg_wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // upper twelve bits hold their reset pattern; protect enable never drops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            msw_reg <= CRI_MSW_RST;
            store_status_word_instr_reg <= 1'b0;
        end else begin
            if (load_status_word_instr) begin
                msw_reg[3:1] <= load_status_word_instr_data[3:1];
                msw_reg[CRI_MSW_PE] <= msw_reg[CRI_MSW_PE] | load_status_word_instr_data[CRI_MSW_PE];
            end
            store_status_word_instr_reg <= store_status_word_instr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            exec_reg <= 1'b0;
            fetch_reg <= 1'b0;
            mem_valid_reg <= 1'b0;
            phys_reg <= 24'h000000;
            bhe_reg <= 1'b0;
            halted_reg <= 1'b0;
        end else begin
            exec_reg <= (state_next == CRI_RUN);
            halted_reg <= (state_next == CRI_HALT);
            fetch_reg <= (state_reg == CRI_RESET) && (state_next == CRI_RUN);
            mem_valid_reg <= mem_go && (state_next == CRI_RUN);
            if (state_reg == CRI_RESET) begin
                phys_reg <= {4'h0, cri_phys(cs_reg, ip_reg)};
                bhe_reg <= 1'b0;
            end else if (mem_go) begin
                // lines 20 to 23 stay low in real mode
                phys_reg <= {4'h0, cri_phys(mem.sel, mem.off)};
                bhe_reg <= mem.word || mem.off[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            frame_valid_reg <= 1'b0;
            frame_reg <= '0;
        end else begin
            frame_valid_reg <= (state_reg == CRI_SVC) && any_pend;
            // an empty service pass must not overwrite the frame already pushed
            if (state_reg == CRI_SVC && any_pend) begin
                frame_reg <= '{flags: flags_reg, cs: cs_reg, ip: ip_reg, vector: pick_vec};
            end
        end
    end

    assign exec_enable = exec_reg;
    assign fetch_start = fetch_reg;
    assign mem_valid = mem_valid_reg;
    assign phys_addr = phys_reg;
    assign high_byte_enable = bhe_reg;
    assign frame_valid = frame_valid_reg;
    assign frame = frame_reg;
    assign code_segment = cs_reg;
    assign instruction_pointer = ip_reg;
    assign data_segment = ds_reg;
    assign extra_segment = es_reg;
    assign stack_segment = ss_reg;
    assign flag_word = flags_reg;
    assign machine_status_word = msw_reg;
    assign store_status_word_instr_valid = store_status_word_instr_reg;
    assign protected_mode = msw_reg[CRI_MSW_PE];
    assign halted = halted_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_reset_values: assert property (!$past(reset_n) |-> cs_reg == CRI_CS_RST
        && ip_reg == CRI_IP_RST && flags_reg == CRI_FLAGS_RST && msw_reg == CRI_MSW_RST
        && ds_reg == 16'h0000 && !exec_enable && !mem_valid)
        else $error("reset state wrong");
    a_boot_fetch: assert property (fetch_start |-> phys_addr == CRI_BOOT_ADDR
        && exec_enable && $past(state_reg == CRI_RESET))
        else $error("boot fetch address wrong");
    a_pe_sticky: assert property ($past(msw_reg[CRI_MSW_PE]) |-> msw_reg[CRI_MSW_PE])
        else $error("protect enable cleared");
    a_esc_trap: assert property (running && coproc_escape_instr && msw_reg[CRI_MSW_EM]
        |=> exc_pend_reg && exc_vec_reg == CRI_VEC_NOCOP)
        else $error("escape did not trap");
    a_wait_trap: assert property (running && coproc_wait_instr && !coproc_escape_instr
        && msw_reg[3:1] == 3'b101 |=> exc_pend_reg && exc_vec_reg == CRI_VEC_NOCOP)
        else $error("wait did not trap");
    a_step_order: assert property (state_reg == CRI_SVC && !exc_pend_reg && step_pend_reg
        |=> frame_valid && frame.vector == CRI_VEC_STEP)
        else $error("step not taken first");
    a_wrap_trap: assert property (trap_wrap && !trap_nocop |=> !mem_valid
        && exc_pend_reg && exc_vec_reg == CRI_VEC_WRAP)
        else $error("wrap not trapped");
    a_halt_quiet: assert property (halted && $past(halted) |-> !exec_enable && !mem_valid)
        else $error("activity in halt");
    a_halt_exit: assert property (state_reg == CRI_HALT && nmi_ok
        |=> state_reg == CRI_SVC ##1 frame_valid && frame.vector == CRI_VEC_NMI)
        else $error("nmi did not end halt");
    a_chain_first: assert property (state_reg == CRI_WAIT && entry_valid && any_pend
        |=> !exec_enable && cs_reg == $past(entry_cs) && !flags_reg[CRI_FLAG_IF])
        else $error("handler ran before chained request");
    a_maskable_request_masked: assert property (state_reg == CRI_SVC && !flags_reg[CRI_FLAG_IF]
        && !exc_pend_reg && !step_pend_reg && !nmi_ok && !ovr_ok |=> !frame_valid)
        else $error("masked request serviced");
    a_addr_high: assert property (mem_valid |-> phys_addr[23:20] == 4'h0)
        else $error("upper address lines driven");
endmodule // cri_ctrl

/* File: testbench/cri_far_model.sv */
`timescale 1ns/100ps
module cri_far_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic frame_valid,
    output logic entry_valid,
    output logic [15:0] entry_cs,
    output logic [15:0] entry_ip,
    output logic [15:0] last_cs,
    output logic [15:0] last_ip
);
    int wait_cnt;
    logic [15:0] tmp_cs;
    logic [15:0] tmp_ip;
    ////////////////////////////////////////////////////////////////
    // handler entry answers a pushed frame after 1 to 6 idle cycles
    always @(posedge clk) begin
        if (!reset_n) begin
            entry_valid <= 1'b0;
            entry_cs <= 16'h0000;
            entry_ip <= 16'h0000;
            wait_cnt <= -1;
        end else if (frame_valid) begin
            wait_cnt <= $urandom_range(0, 5);
            entry_valid <= 1'b0;
        end else if (wait_cnt == 0) begin
            tmp_cs = 16'($urandom);
            tmp_ip = 16'($urandom);
            entry_valid <= 1'b1;
            entry_cs <= tmp_cs;
            entry_ip <= tmp_ip;
            last_cs <= tmp_cs;
            last_ip <= tmp_ip;
            wait_cnt <= -1;
        end else begin
            // stale entry must not be mistaken for a valid one
            entry_valid <= 1'b0;
            entry_cs <= ~entry_cs;
            entry_ip <= ~entry_ip;
            if (wait_cnt > 0) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule // cri_far_model

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import cri_pkg::*;
    localparam logic [10:0] P_SW = 11'h001, P_OV = 11'h002, P_ESC = 11'h004, P_WAIT = 11'h008;
    localparam logic [10:0] P_LOAD_STATUS_WORD_INSTR = 11'h010, P_STORE_STATUS_WORD_INSTR = 11'h020, P_HALT = 11'h040;
    localparam logic [10:0] P_IRET = 11'h080, P_FLG = 11'h100, P_DONE = 11'h200, P_MEM = 11'h400;
    logic clk, reset_n, nmi_pin, maskable_request, instr_done, flags_wr, sw_int, ovrun_req;
    logic coproc_escape_instr, coproc_wait_instr, load_status_word_instr, mem_req;
    logic store_status_word_instr, halt_instr, iret_done, entry_valid;
    logic exec_enable, fetch_start, mem_valid, high_byte_enable, frame_valid;
    logic store_status_word_instr_valid, protected_mode, halted;
    logic [1:0] seg_wr_sel;
    logic [7:0] maskable_request_vector, sw_vector;
    logic [10:0] pv;
    logic [15:0] next_cs, next_ip, flags_wr_data, seg_wr_data, load_status_word_instr_data, entry_cs, entry_ip;
    logic [15:0] last_cs, last_ip, code_segment, instruction_pointer, data_segment;
    logic [15:0] extra_segment, stack_segment, flag_word, machine_status_word;
    logic [23:0] phys_addr;
    cri_mem_s mem;
    cri_frame_s frame;
    int mismatches, tests_run, cycles;

    // one-cycle strobes share a vector so a pulse is one assignment
    assign {mem_req, instr_done, flags_wr, iret_done, halt_instr, store_status_word_instr,
            load_status_word_instr, coproc_wait_instr, coproc_escape_instr, ovrun_req,
            sw_int} = pv;

    cri_ctrl #(.RESET_GAP(2)) dut_u (.*);
    cri_far_model far_u (.*);

    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(string what, logic [47:0] exp, logic [47:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    function automatic logic [23:0] exp_phys(logic [15:0] s, logic [15:0] o);
        logic [19:0] a;
        a = {s, 4'h0} + {4'h0, o};
        return {4'h0, a};
    endfunction

    task automatic fire(logic [10:0] m);
        @(posedge clk);
        pv <= m;
        @(posedge clk);
        pv <= '0;
        #1;
    endtask

    task automatic wait_on(string what, ref logic sig);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(what, 1'b1, sig);
    endtask

    task automatic wait_frame(logic [7:0] vec);
        wait_on("frame push", frame_valid);
        check("frame vector", vec, frame.vector);
        check("run during service", 1'b0, exec_enable);
        @(posedge clk);
        #1;
    endtask

    task automatic serve(logic [7:0] vec);
        wait_frame(vec);
        wait_on("run resumed", exec_enable);
        check("entry cs", last_cs, code_segment);
        check("entry ip", last_ip, instruction_pointer);
    endtask

    task automatic expect_trap(logic t);
        if (t) serve(8'h07);
        else repeat (10) begin
            @(posedge clk);
            #1;
            check("no trap", 1'b0, frame_valid);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        // whole run needs a few hundred cycles
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        logic [15:0] hv, o;
        logic [15:0] sd [4];
        logic [7:0] sv;
        logic [2:0] enc [5];
        enc = '{3'b000, 3'b010, 3'b110, 3'b001, 3'b101};
        {reset_n, nmi_pin, maskable_request, pv, seg_wr_sel, maskable_request_vector, sw_vector} = '0;
        {next_cs, next_ip, flags_wr_data, seg_wr_data, load_status_word_instr_data, mem} = '0;
        void'($urandom(32'h7eb1f5b5));
        repeat (4) @(posedge clk);
        #1;
        check("run in reset", 1'b0, exec_enable);
        check("flags", 16'h0002, flag_word);
        check("ip", 16'hfff0, instruction_pointer);
        check("cs", 16'hf000, code_segment);
        check("seg", 16'h0000, data_segment | extra_segment | stack_segment);
        check("status word", 16'hfff0, machine_status_word);
        @(posedge clk);
        reset_n <= 1'b1;
        wait_on("first fetch", fetch_start);
        check("boot addr", 24'h0ffff0, phys_addr);
        wait_on("run", exec_enable);
        for (int k = 0; k < 24; k++) begin
            @(posedge clk);
            o = (k == 0) ? 16'hfff0 : 16'($urandom_range(0, 16'hfffe));
            hv = (k == 0) ? 16'hffff : 16'($urandom);
            mem <= '{sel: hv, off: o, word: 1'($urandom)};
            fire(P_MEM);
            check("mem valid", 1'b1, mem_valid);
            check("phys addr", exp_phys(hv, o), phys_addr);
            check("byte enable", mem.word | o[0], high_byte_enable);
        end
        @(posedge clk);
        mem <= '{sel: 16'($urandom), off: 16'hffff, word: 1'b1};
        fire(P_MEM);
        check("wrap access", 1'b0, mem_valid);
        serve(8'h0d);
        for (int k = 1; k < 4; k++) begin
            @(posedge clk);
            sd[k] = 16'($urandom);
            seg_wr_sel <= 2'(k);
            seg_wr_data <= sd[k];
        end
        @(posedge clk);
        seg_wr_sel <= 2'h0;
        #1;
        check("segments", {sd[1], sd[2], sd[3]}, {data_segment, extra_segment, stack_segment});
        @(posedge clk);
        sv = 8'($urandom_range(32, 255));
        sw_vector <= sv;
        fire(P_SW | P_OV);
        wait_frame(sv);
        serve(8'h09);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            load_status_word_instr_data <= {12'h000, enc[k], 1'b0};
            fire(P_LOAD_STATUS_WORD_INSTR);
            check("status word", {12'hfff, enc[k], 1'b0}, machine_status_word);
            fire(P_STORE_STATUS_WORD_INSTR);
            check("store ack", 1'b1, store_status_word_instr_valid);
            fire(P_ESC);
            expect_trap(enc[k][1] | enc[k][2]);
            fire(P_WAIT);
            expect_trap(enc[k][0] & enc[k][2]);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            flags_wr_data <= {6'h00, k[0], 9'h000};
            sv = 8'($urandom);
            maskable_request_vector <= sv;
            hv = 16'($urandom);
            next_cs <= code_segment;
            next_ip <= hv;
            fire(P_FLG);
            fire(P_HALT | P_DONE);
            fire(P_MEM);
            check("bus while halted", 1'b0, mem_valid);
            @(posedge clk);
            maskable_request <= 1'b1;
            nmi_pin <= 1'b0;
            if (k == 0) begin
                repeat (12) @(posedge clk);
                #1;
                check("masked wake", 1'b1, halted);
                @(posedge clk);
                maskable_request <= 1'b0;
                nmi_pin <= 1'b1;
            end
            serve(k == 0 ? 8'h02 : sv);
            check("return ip", hv, frame.ip);
            check("return cs", next_cs, frame.cs);
            check("saved flags", {6'h00, k[0], 9'h002}, frame.flags);
            @(posedge clk);
            {maskable_request, nmi_pin} <= 2'b00;
            fire(P_IRET);
        end
        @(posedge clk);
        flags_wr_data <= 16'h0100;
        fire(P_FLG);
        fire(P_DONE | P_OV);
        wait_frame(8'h01);
        check("step return ip", next_ip, frame.ip);
        serve(8'h09);
        @(posedge clk);
        load_status_word_instr_data <= 16'h0001;
        fire(P_LOAD_STATUS_WORD_INSTR);
        check("protected", 1'b1, protected_mode);
        @(posedge clk);
        load_status_word_instr_data <= 16'h0000;
        fire(P_LOAD_STATUS_WORD_INSTR);
        check("pe sticky", 1'b1, machine_status_word[0]);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("status word", 16'hfff0, machine_status_word);
        conclude();
    end
endmodule // testbench
